// [common/ccp_pkg.sv]
//==========================================================
// Clock controller constants
package ccp_pkg;
  // Register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  //==========================================================
  // Register offsets
  localparam logic [7:0] OFS_RATE_0 = 8'h8F; // clock_rate_control_0
  localparam logic [7:0] OFS_RATE_1 = 8'hAF; // clock_rate_control_1
  localparam logic [7:0] OFS_SYNTH_CTRL = 8'hA3; // synth_control_reg
  localparam logic [7:0] OFS_SYNTH_DIV = 8'hA4; // synth_divider_reg
  //==========================================================
  // Field positions
  localparam int unsigned BIT_CORE_DBL = 0; // core_double_speed
  localparam int unsigned BIT_UNIT_LSB = 1; // timer0 .. watchdog in rate 0
  localparam int unsigned BIT_SPI = 0; // serial_periph_speed_sel in rate 1
  localparam int unsigned BIT_SYNTH_EN = 1; // synth_enable
  localparam int unsigned BIT_LOCK = 0; // synth_lock_flag
  localparam int unsigned DIV_N_LSB = 0; // reference divider minus one
  localparam int unsigned DIV_R_LSB = 4; // feedback divider minus one
  localparam int unsigned DIV_FLD_W = 4;
  // Writable bits; others read zero, except BIT_LOCK of synth_control_reg
  localparam logic [7:0] MASK_RATE_0 = 8'h7F;
  localparam logic [7:0] MASK_RATE_1 = 8'h01;
  localparam logic [7:0] MASK_SYNTH_CTRL = 8'h02;
  // Reset values
  localparam logic [7:0] RST_RATE_0 = 8'h00;
  localparam logic [7:0] RST_RATE_1 = 8'h00;
  localparam logic [7:0] RST_SYNTH_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNTH_DIV = 8'h00;
  //==========================================================
  // Divider counts, in oscillator periods
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] PER_STD = 5'h0C; // 12 periods per cycle
  localparam logic [4:0] PER_DBL = 5'h06; // 6 periods per cycle
  localparam logic [4:0] PCLK_STD = 5'h02; // peripheral clock = osc/2
  localparam logic [4:0] PCLK_DBL = 5'h01; // peripheral clock = osc
  localparam int unsigned NUM_UNITS = 7;
  // Digital oscillator and lock detector
  localparam int unsigned DCO_W = 8;
  localparam logic [7:0] DCO_INIT = 8'h10;
  localparam logic [7:0] DCO_MIN = 8'h01;
  localparam logic [7:0] DCO_MAX = 8'hFF;
  localparam int unsigned ERR_W = 4;
  localparam logic [3:0] LOCK_TOL = 4'h2; // phase error allowed, cycles
  localparam logic [3:0] LOCK_COUNT = 4'h4; // good compares to declare lock
endpackage : ccp_pkg

// [rtl/ccp_tick_div.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// Enable-pulse divider: one pulse every load_val input ticks
module ccp_tick_div #(
  parameter int unsigned W = 5 // counter width
) (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic run, // gate; low holds counter cleared
  input wire logic tick_in, // input rate enable
  input wire logic [W-1:0] load_val, // ticks per output pulse, 1 or more
  output logic tick_out // registered output pulse
);
  logic [W-1:0] cnt_q; // ticks seen since last pulse
  // Count and pulse; >= guards a load that shrinks mid-count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else if (tick_in && (cnt_q >= load_val - W'(1))) begin
      cnt_q <= '0;
      tick_out <= 1'b1;
    end else begin
      if (tick_in) begin
        cnt_q <= cnt_q + W'(1);
      end
      tick_out <= 1'b0;
    end
  end
endmodule : ccp_tick_div
`default_nettype wire

// [rtl/ccp_pfd.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// Phase-frequency detector with lock detector
module ccp_pfd (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic enable, // synthesizer running
  input wire logic ref_tick, // reference edge
  input wire logic fb_tick, // feedback edge
  output logic up, // reference leads: speed up
  output logic down, // feedback leads: slow down
  output logic locked // lock detected
);
  import ccp_pkg::*;
  logic ref_pend_q; // reference seen, waiting for feedback
  logic fb_pend_q; // feedback seen, waiting for reference
  logic [ERR_W-1:0] err_q; // cycles between the two edges
  logic [ERR_W-1:0] good_q; // consecutive good compares
  logic done; // a compare completes
  logic ok; // completed compare within tolerance
  logic slip; // same edge twice: cycle slip
  assign up = ref_pend_q;
  assign down = fb_pend_q;
  //==========================================================
  // Compare outcome
  always_comb begin
    done = enable && ((ref_tick && (fb_tick || fb_pend_q)) || (fb_tick && ref_pend_q));
    ok = (ref_pend_q || fb_pend_q) ? (err_q <= LOCK_TOL) : 1'b1;
    slip = enable && ((ref_tick && ref_pend_q && !fb_tick) ||
                      (fb_tick && fb_pend_q && !ref_tick));
  end
  // Edge ordering: first edge opens an up or down window
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_pend_q <= 1'b0;
      fb_pend_q <= 1'b0;
      err_q <= '0;
    end else if (!enable) begin
      ref_pend_q <= 1'b0;
      fb_pend_q <= 1'b0;
      err_q <= '0;
    end else if (ref_tick && fb_tick) begin
      ref_pend_q <= 1'b0;
      fb_pend_q <= 1'b0;
      err_q <= '0;
    end else if (ref_tick) begin
      ref_pend_q <= !fb_pend_q;
      fb_pend_q <= 1'b0;
      err_q <= '0;
    end else if (fb_tick) begin
      fb_pend_q <= !ref_pend_q;
      ref_pend_q <= 1'b0;
      err_q <= '0;
    end else if ((ref_pend_q || fb_pend_q) && (err_q != '1)) begin
      err_q <= err_q + ERR_W'(1);
    end
  end
  // Lock: set after enough good compares, dropped on any bad one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      good_q <= '0;
      locked <= 1'b0;
    end else if (!enable || slip || (done && !ok)) begin
      good_q <= '0;
      locked <= 1'b0;
    end else if (done && ok) begin
      if (good_q >= LOCK_COUNT - ERR_W'(1)) begin
        locked <= 1'b1;
      end else begin
        good_q <= good_q + ERR_W'(1);
      end
    end
  end
  //==========================================================
  // Checks
  property p_ref_up;
    @(posedge mclk) disable iff (!reset_n)
    (enable && ref_tick && !fb_tick && !fb_pend_q) |=> up;
  endproperty
  a_ref_up: assert property (p_ref_up) else $error("lead reference gave no up");
  property p_fb_down;
    @(posedge mclk) disable iff (!reset_n)
    (enable && fb_tick && !ref_tick && !ref_pend_q) |=> (down && !up);
  endproperty
  a_fb_down: assert property (p_fb_down) else $error("lead feedback gave no down");
endmodule : ccp_pfd
`default_nettype wire

// [rtl/ccp_clock_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// Overview of operation
// - Generate CPU, peripheral and USB clock enables.
// - Gate each clock by power reduction mode.
// - Oscillator inverter off unless synthesizer used.
// - USB clock locked to peripheral clock reference.
// - Detector emits up/down by feedback edge position.
// - Setting synth_enable starts synthesized clock.
// - Hardware sets synth_lock_flag on lock.
// - Clearing synth_enable stops the synthesizer.
// - Hardware clears lock flag on lock loss.
// - Core cycle 12 periods, 6 when doubled.
// - Unit speed bits matter only when doubled.
module ccp_clock_ctrl (
  input wire logic mclk, // oscillator-rate system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [ccp_pkg::ADDR_W-1:0] reg_addr, // register address
  input wire logic [ccp_pkg::DATA_W-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [ccp_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic idle_req, // idle mode: CPU clock stopped
  input wire logic pdown_req, // power-down: all clocks stopped
  output logic cpu_cycle_en, // CPU machine-cycle pulse
  output logic per_clk_en, // peripheral clock pulse
  output logic [ccp_pkg::NUM_UNITS-1:0] unit_cycle_en, // per-unit cycle pulses
  output logic usb_clk_en, // synthesized USB clock pulse
  output logic osc_inv_en // oscillator inverter enable
);
  import ccp_pkg::*;
  //==========================================================
  // Registers
  logic [7:0] rate0_q; // clock_rate_control_0
  logic [7:0] rate1_q; // clock_rate_control_1
  logic [7:0] synth_ctrl_q; // synth_control_reg, enable bit only
  logic [7:0] synth_div_q; // synth_divider_reg
  logic lock_s1_q; // synchronizer stage one
  logic synth_lock_flag_q; // synchronized lock flag
  logic [7:0] rdata_d; // read mux
  // Decoded controls
  logic core_double_speed; // core_double_speed bit
  logic synth_enable; // synth_enable bit
  logic [NUM_UNITS-1:0] unit_sel; // per-unit speed select bits
  logic cpu_run; // CPU clock allowed
  logic per_run; // peripheral and USB clocks allowed
  logic [CNT_W-1:0] cpu_load; // periods per machine cycle
  logic [CNT_W-1:0] pclk_load; // periods per peripheral clock
  logic [CNT_W-1:0] ref_load; // reference divide
  logic [CNT_W-1:0] fb_load; // feedback divide
  // Synthesizer
  logic ref_tick; // divided reference
  logic fb_tick; // divided feedback
  logic vco_tick_q; // digital oscillator output
  logic [DCO_W-1:0] dco_cnt_q; // oscillator phase counter
  logic [DCO_W-1:0] period_q; // oscillator period, cycles
  logic pfd_up; // speed up request
  logic pfd_down; // slow down request
  logic up_d1_q; // delayed up, for end of window
  logic down_d1_q; // delayed down
  logic pfd_locked; // raw lock

  //==========================================================
  // Register writes; reserved bits are masked and read zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rate0_q <= RST_RATE_0;
      rate1_q <= RST_RATE_1;
      synth_ctrl_q <= RST_SYNTH_CTRL;
      synth_div_q <= RST_SYNTH_DIV;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_RATE_0: rate0_q <= reg_wdata & MASK_RATE_0;
        OFS_RATE_1: rate1_q <= reg_wdata & MASK_RATE_1;
        OFS_SYNTH_CTRL: synth_ctrl_q <= reg_wdata & MASK_SYNTH_CTRL;
        OFS_SYNTH_DIV: synth_div_q <= reg_wdata;
        default: begin
          // Unmapped write ignored
        end
      endcase
    end
  end

  // Lock flag crosses a two-flop synchronizer before software sees it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_s1_q <= 1'b0;
      synth_lock_flag_q <= 1'b0;
    end else begin
      lock_s1_q <= pfd_locked;
      synth_lock_flag_q <= lock_s1_q;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      OFS_RATE_0: rdata_d = rate0_q;
      OFS_RATE_1: rdata_d = rate1_q;
      OFS_SYNTH_CTRL: begin
        rdata_d = synth_ctrl_q;
        rdata_d[BIT_LOCK] = synth_lock_flag_q;
      end
      OFS_SYNTH_DIV: rdata_d = synth_div_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data registered, valid only the cycle after the strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //==========================================================
  // Rate and gating decode
  always_comb begin
    core_double_speed = rate0_q[BIT_CORE_DBL];
    synth_enable = synth_ctrl_q[BIT_SYNTH_EN];
    unit_sel = {rate1_q[BIT_SPI], rate0_q[BIT_UNIT_LSB +: NUM_UNITS-1]};
    cpu_run = !idle_req && !pdown_req;
    per_run = !pdown_req;
    cpu_load = core_double_speed ? PER_DBL : PER_STD;
    pclk_load = core_double_speed ? PCLK_DBL : PCLK_STD;
    // Field plus one; 5 bits so a 16 divide fits
    ref_load = {1'b0, synth_div_q[DIV_N_LSB +: DIV_FLD_W]} + CNT_W'(1);
    fb_load = {1'b0, synth_div_q[DIV_R_LSB +: DIV_FLD_W]} + CNT_W'(1);
  end

  // Inverter only runs while the synthesizer feeds the USB clock
  assign osc_inv_en = synth_enable;

  //==========================================================
  // CPU and peripheral clocks
  ccp_tick_div #(.W(CNT_W)) u_cpu_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(cpu_run),
    .tick_in(1'b1),
    .load_val(cpu_load),
    .tick_out(cpu_cycle_en)
  );
  ccp_tick_div #(.W(CNT_W)) u_per_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(per_run),
    .tick_in(1'b1),
    .load_val(pclk_load),
    .tick_out(per_clk_en)
  );

  // Per-unit cycles; a unit bit counts only in double-speed mode
  for (genvar gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
    logic [CNT_W-1:0] unit_load; // periods per unit cycle
    assign unit_load = (core_double_speed && !unit_sel[gi]) ? PER_DBL : PER_STD;
    ccp_tick_div #(.W(CNT_W)) u_unit_div (
      .mclk(mclk),
      .reset_n(reset_n),
      .run(per_run),
      .tick_in(1'b1),
      .load_val(unit_load),
      .tick_out(unit_cycle_en[gi])
    );
  end

  //==========================================================
  // Synthesizer: reference from peripheral clock, feedback from digital oscillator
  ccp_tick_div #(.W(CNT_W)) u_ref_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(synth_enable),
    .tick_in(per_clk_en),
    .load_val(ref_load),
    .tick_out(ref_tick)
  );
  ccp_tick_div #(.W(CNT_W)) u_fb_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(synth_enable),
    .tick_in(vco_tick_q),
    .load_val(fb_load),
    .tick_out(fb_tick)
  );
  ccp_pfd u_pfd (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(synth_enable),
    .ref_tick(ref_tick),
    .fb_tick(fb_tick),
    .up(pfd_up),
    .down(pfd_down),
    .locked(pfd_locked)
  );

  // Period steps once per window, at its close; a compare of coincident edges opens no window and gives no step
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      up_d1_q <= 1'b0;
      down_d1_q <= 1'b0;
      period_q <= DCO_INIT;
    end else if (!synth_enable) begin
      up_d1_q <= 1'b0;
      down_d1_q <= 1'b0;
      period_q <= DCO_INIT;
    end else begin
      up_d1_q <= pfd_up;
      down_d1_q <= pfd_down;
      if (up_d1_q && !pfd_up && (period_q > DCO_MIN)) begin
        period_q <= period_q - DCO_W'(1);
      end else if (down_d1_q && !pfd_down && (period_q < DCO_MAX)) begin
        period_q <= period_q + DCO_W'(1);
      end
    end
  end

  // Digital oscillator; integer period limits reachable ratios
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dco_cnt_q <= '0;
      vco_tick_q <= 1'b0;
    end else if (!synth_enable) begin
      dco_cnt_q <= '0;
      vco_tick_q <= 1'b0;
    end else if (dco_cnt_q >= period_q - DCO_W'(1)) begin
      dco_cnt_q <= '0;
      vco_tick_q <= 1'b1;
    end else begin
      dco_cnt_q <= dco_cnt_q + DCO_W'(1);
      vco_tick_q <= 1'b0;
    end
  end

  // USB clock pulse, stopped in power-down
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      usb_clk_en <= 1'b0;
    end else begin
      usb_clk_en <= vco_tick_q && per_run;
    end
  end

  //==========================================================
  // Checks
  property p_cpu_gate;
    @(posedge mclk) disable iff (!reset_n)
    (idle_req || pdown_req) |=> !cpu_cycle_en;
  endproperty
  a_cpu_gate: assert property (p_cpu_gate) else $error("CPU pulse while gated");
  property p_osc_inv;
    @(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == OFS_SYNTH_CTRL) |=> (osc_inv_en == $past(reg_wdata[BIT_SYNTH_EN]));
  endproperty
  a_osc_inv: assert property (p_osc_inv) else $error("inverter enable wrong");
  property p_usb_off;
    @(posedge mclk) disable iff (!reset_n)
    !synth_enable |=> ##1 !usb_clk_en;
  endproperty
  a_usb_off: assert property (p_usb_off) else $error("USB pulse with synth off");
  property p_lock_set;
    @(posedge mclk) disable iff (!reset_n)
    pfd_locked |-> ##2 synth_lock_flag_q;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock flag not set");
  property p_lock_clr;
    @(posedge mclk) disable iff (!reset_n)
    !pfd_locked |-> ##2 !synth_lock_flag_q;
  endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("lock flag not cleared");
  property p_cpu_rate;
    @(posedge mclk) disable iff (!reset_n)
    (cpu_cycle_en && core_double_speed && cpu_run) ##1
      (core_double_speed && cpu_run) [*5] |=> cpu_cycle_en;
  endproperty
  a_cpu_rate: assert property (p_cpu_rate) else $error("double-speed cycle not 6");
  property p_unit_gap;
    @(posedge mclk) disable iff (!reset_n)
    unit_cycle_en[0] |=> !unit_cycle_en[0] [*5];
  endproperty
  a_unit_gap: assert property (p_unit_gap) else $error("unit cycle under 6");
  property p_rd_div;
    @(posedge mclk) disable iff (!reset_n)
    (reg_rd && reg_addr == OFS_SYNTH_DIV && !reg_wr) |=> (reg_rdata == synth_div_q);
  endproperty
  a_rd_div: assert property (p_rd_div) else $error("divider readback wrong");
  c_lock: cover property (@(posedge mclk) disable iff (!reset_n) $rose(synth_lock_flag_q));
  c_idle: cover property (@(posedge mclk) disable iff (!reset_n) idle_req && per_clk_en);
  c_dbl: cover property (@(posedge mclk) disable iff (!reset_n)
    cpu_cycle_en && core_double_speed);
endmodule : ccp_clock_ctrl
`default_nettype wire

// [tb/ccp_clock_sink.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// Clock consumers: CPU, peripherals and USB side of the block
module ccp_clock_sink (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic cpu_cycle_en, // CPU machine-cycle pulse
  input wire logic per_clk_en, // peripheral clock pulse
  input wire logic [ccp_pkg::NUM_UNITS-1:0] unit_cycle_en, // per-unit pulses
  input wire logic usb_clk_en, // synthesized clock pulse
  output logic [8:0][7:0] gap_q, // last spacing: cpu, per, units 0..6
  output logic [2:0][15:0] cnt_q // pulse counts: cpu, per, usb
);
  import ccp_pkg::*;
  logic [8:0] pulse; // streams whose spacing is measured
  logic [8:0][7:0] run_q; // cycles since last pulse
  assign pulse = {unit_cycle_en, per_clk_en, cpu_cycle_en};
  //==========================================================
  // Spacing, saturating so a stopped clock cannot wrap back
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= '0;
      gap_q <= '0;
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (pulse[i]) begin // Pulse closes one interval
          gap_q[i] <= run_q[i] + 8'h01;
          run_q[i] <= 8'h00;
        end else if (run_q[i] != 8'hFF) begin
          run_q[i] <= run_q[i] + 8'h01;
        end
      end
    end
  end
  //==========================================================
  // Pulse counters; the bench compares differences only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q[0] <= cnt_q[0] + {15'h0000, cpu_cycle_en};
      cnt_q[1] <= cnt_q[1] + {15'h0000, per_clk_en};
      cnt_q[2] <= cnt_q[2] + {15'h0000, usb_clk_en};
    end
  end
endmodule : ccp_clock_sink
`default_nettype wire

// [tb/test_pll_clock_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module test_pll_clock_controller;
  import ccp_pkg::*;
  //==========================================================
  // Signals
  logic mclk; // 200 MHz clock
  logic reset_n; // async reset, active low
  logic [7:0] reg_addr; // register address
  logic [7:0] reg_wdata; // write data
  logic reg_wr; // write strobe
  logic reg_rd; // read strobe
  logic [7:0] reg_rdata; // read data
  logic idle_req; // idle mode
  logic pdown_req; // power-down mode
  logic cpu_cycle_en; // CPU pulse
  logic per_clk_en; // peripheral pulse
  logic [NUM_UNITS-1:0] unit_cycle_en; // unit pulses
  logic usb_clk_en; // synthesized pulse
  logic osc_inv_en; // inverter enable
  logic [8:0][7:0] gap; // measured spacings
  logic [2:0][15:0] cnt; // pulse counts
  int num_errors = 0; // mismatches
  int total_checks = 0; // comparisons
  int cycles = 0; // timeout counter
  logic [7:0] rd; // last read value
  logic [7:0] r0; // rate 0 setting
  logic [7:0] r1; // rate 1 setting
  logic [15:0] c0; // count snapshot
  logic [15:0] c1; // second count snapshot
  logic [7:0] ue; // expected unit spacing
  logic ub; // unit speed bit
  localparam int LIMIT = 40000; // far above the whole sequence
  localparam logic [7:0] ADDRS [5] = '{OFS_RATE_0, OFS_RATE_1, OFS_SYNTH_DIV, OFS_SYNTH_CTRL, 8'h10};
  localparam logic [7:0] MASKS [5] = '{8'h7F, 8'h01, 8'hFF, 8'h02, 8'h00};
  localparam logic [7:0] RATES [4] = '{8'h00, 8'h01, 8'h7F, 8'h55};
  //==========================================================
  // Design and clock consumers
  ccp_clock_ctrl DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .idle_req(idle_req), .pdown_req(pdown_req), .cpu_cycle_en(cpu_cycle_en),
    .per_clk_en(per_clk_en), .unit_cycle_en(unit_cycle_en), .usb_clk_en(usb_clk_en),
    .osc_inv_en(osc_inv_en));
  ccp_clock_sink sink (.mclk(mclk), .reset_n(reset_n), .cpu_cycle_en(cpu_cycle_en),
    .per_clk_en(per_clk_en), .unit_cycle_en(unit_cycle_en), .usb_clk_en(usb_clk_en),
    .gap_q(gap), .cnt_q(cnt));
  //==========================================================
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin // Hung: count it and close
      num_errors++;
      stop_test();
    end
  end
  //==========================================================
  // Register port tasks, one-cycle strobes
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk); // Data stands only in this cycle
    d = reg_rdata;
  endtask : reg_read
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  //==========================================================
  // Test sequence
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    idle_req = 1'b0;
    pdown_req = 1'b0;
    reset_n = 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values, then writable bits; unmapped place stays zero
    for (int i = 0; i < 5; i++) begin
      reg_read(ADDRS[i], rd);
      check("reset value", rd, 8'h00);
      reg_write(ADDRS[i], 8'hFF);
      reg_read(ADDRS[i], rd);
      check("masked readback", rd, MASKS[i]);
    end
    check("inverter on", {7'h00, osc_inv_en}, 8'h01);
    reg_write(OFS_SYNTH_CTRL, 8'h00);
    @(negedge mclk);
    check("inverter off", {7'h00, osc_inv_en}, 8'h00);
    $display("test registers done");
    // Machine and unit cycle lengths over the rate settings
    for (int k = 0; k < 4; k++) begin
      r0 = RATES[k];
      r1 = {7'h00, r0[2]};
      reg_write(OFS_RATE_0, r0);
      reg_write(OFS_RATE_1, r1);
      repeat (40) @(posedge mclk);
      check("cpu spacing", gap[0], r0[0] ? 8'h06 : 8'h0C);
      check("per spacing", gap[1], r0[0] ? 8'h01 : 8'h02);
      for (int u = 0; u < NUM_UNITS; u++) begin
        ub = (u < 6) ? r0[u+1] : r1[0];
        ue = (r0[0] && !ub) ? 8'h06 : 8'h0C;
        check("unit spacing", gap[u+2], ue);
      end
    end
    $display("test rates done");
    // Power reduction gating
    reg_write(OFS_RATE_0, 8'h00);
    idle_req <= 1'b1;
    repeat (4) @(posedge mclk);
    c0 = cnt[0];
    c1 = cnt[1];
    repeat (40) @(posedge mclk);
    check("idle cpu pulses", 8'(cnt[0] - c0), 8'h00);
    check("idle per pulses", 8'(cnt[1] - c1), 8'h14);
    pdown_req <= 1'b1;
    repeat (4) @(posedge mclk);
    c1 = cnt[1];
    repeat (40) @(posedge mclk);
    check("pdown per pulses", 8'(cnt[1] - c1), 8'h00);
    idle_req <= 1'b0;
    pdown_req <= 1'b0;
    repeat (40) @(posedge mclk);
    check("cpu after wake", gap[0], 8'h0C);
    $display("test gating done");
    // Synthesizer: 1:1 and 1:2 ratios against a 2-cycle reference
    for (int k = 0; k < 2; k++) begin
      reg_write(OFS_SYNTH_DIV, 8'(k));
      reg_write(OFS_SYNTH_CTRL, 8'h02);
      @(negedge mclk);
      check("inverter enabled", {7'h00, osc_inv_en}, 8'h01);
      rd = 8'h00;
      for (int t = 0; t < 600 && rd[0] !== 1'b1; t++) begin
        reg_read(OFS_SYNTH_CTRL, rd);
      end
      check("locked status", rd, 8'h03);
      c0 = cnt[2];
      repeat (48) @(posedge mclk);
      c1 = cnt[2] - c0;
      ue = (k == 0) ? 8'h18 : 8'h0C;
      check("usb rate", {7'h00, c1[7:0] + 8'h01 >= ue && c1[7:0] <= ue + 8'h01}, 8'h01);
      reg_write(OFS_SYNTH_CTRL, 8'h00);
      @(negedge mclk);
      check("inverter disabled", {7'h00, osc_inv_en}, 8'h00);
      repeat (4) @(posedge mclk);
      reg_read(OFS_SYNTH_CTRL, rd);
      check("lock cleared", rd, 8'h00);
      c0 = cnt[2];
      repeat (20) @(posedge mclk);
      check("usb stopped", 8'(cnt[2] - c0), 8'h00);
    end
    $display("test synthesizer done");
    stop_test();
  end
endmodule : test_pll_clock_controller
`default_nettype wire
